// file: rtl/udc_bank.sv
// Bank of sixteen up/down pulse counters with an APB register slave.
// Assumes coil pins are asynchronous to pclk and held for over two cycles.
// What this block does
// - Each count coil rising edge counts once.
// - Direction high counts up, low down.
// - Clear coil forces value to zero.
// - Preset coil rising edge loads start value.
// - Upper flag set when value >= upper.
// - Lower flag set when value <= lower.
// - Zero flag set exactly when value zero.
// - Overflow flag pulses one cycle per edge.
// - On overflow the value holds, never wraps.
// - Counting happens only in run mode.
// - Operands are full-range signed 32-bit values.
// - Value is always shown on output port.
// - Sixteen independent counter instances exist.
// - Value output is signed 32-bit, full range.
module udc_bank
  import udc_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [UDC_AW-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [UDC_N-1:0]            count_coil,
  input  wire logic [UDC_N-1:0]            direction_coil,
  input  wire logic [UDC_N-1:0]            clear_coil,
  input  wire logic [UDC_N-1:0]            preset_load_coil,
  output logic      [UDC_N-1:0][UDC_W-1:0] actual_value_out,
  output logic      [UDC_N-1:0]            upper_limit_flag,
  output logic      [UDC_N-1:0]            lower_limit_flag,
  output logic      [UDC_N-1:0]            zero_flag,
  output logic      [UDC_N-1:0]            overflow_flag,
  output logic                             irq
);
  logic [UDC_N-1:0] cnt_s1_reg;
  logic [UDC_N-1:0] cnt_s2_reg;
  logic [UDC_N-1:0] cnt_prev_reg;
  logic [UDC_N-1:0] dir_s1_reg;
  logic [UDC_N-1:0] dir_s2_reg;
  logic [UDC_N-1:0] clr_s1_reg;
  logic [UDC_N-1:0] clr_s2_reg;
  logic [UDC_N-1:0] pre_s1_reg;
  logic [UDC_N-1:0] pre_s2_reg;
  logic [UDC_N-1:0] pre_prev_reg;
  logic [UDC_N-1:0] count_rise;
  logic [UDC_N-1:0] preset_rise;

  logic [31:0]      upper_reg [UDC_N];
  logic [31:0]      lower_reg [UDC_N];
  logic [31:0]      start_reg [UDC_N];
  logic             run_reg;
  logic [15:0]      status_reg;
  logic [15:0]      status_next;
  logic [15:0]      irq_en_reg;
  logic [15:0]      irq_en_next;
  logic             irq_reg;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             setup;
  logic             wr_en;
  logic [UDC_N-1:0] ovf_evt;

  udc_core_if cif [UDC_N] ();

  function automatic logic is_cnt(input logic [UDC_AW-1:0] a);
    is_cnt = a[11:8] == UDC_CNT_PAGE;
  endfunction : is_cnt

  function automatic logic [3:0] cnt_idx(input logic [UDC_AW-1:0] a);
    cnt_idx = a[7:4];
  endfunction : cnt_idx

  function automatic logic [1:0] cnt_sel(input logic [UDC_AW-1:0] a);
    cnt_sel = a[3:2];
  endfunction : cnt_sel

  function automatic logic is_global(input logic [UDC_AW-1:0] a);
    is_global = a == UDC_CTRL || a == UDC_STATUS || a == UDC_IRQ_EN || a == UDC_IRQ_CLR;
  endfunction : is_global

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_reg && pwrite;

  // Coil pins pass two flops before any logic looks at them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_s1_reg <= UDC_RST16;
      cnt_s2_reg <= UDC_RST16;
      dir_s1_reg <= UDC_RST16;
      dir_s2_reg <= UDC_RST16;
      clr_s1_reg <= UDC_RST16;
      clr_s2_reg <= UDC_RST16;
      pre_s1_reg <= UDC_RST16;
      pre_s2_reg <= UDC_RST16;
    end
    else
    begin
      cnt_s1_reg <= count_coil;
      cnt_s2_reg <= cnt_s1_reg;
      dir_s1_reg <= direction_coil;
      dir_s2_reg <= dir_s1_reg;
      clr_s1_reg <= clear_coil;
      clr_s2_reg <= clr_s1_reg;
      pre_s1_reg <= preset_load_coil;
      pre_s2_reg <= pre_s1_reg;
    end
  end

  // Edges are taken once per cycle, so a pulse level must span the sampling.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_prev_reg <= UDC_RST16;
      pre_prev_reg <= UDC_RST16;
    end
    else
    begin
      cnt_prev_reg <= cnt_s2_reg;
      pre_prev_reg <= pre_s2_reg;
    end
  end

  assign count_rise  = cnt_s2_reg & ~cnt_prev_reg;
  assign preset_rise = pre_s2_reg & ~pre_prev_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_reg <= 1'b0;
    else if (wr_en && paddr == UDC_CTRL)
      run_reg <= pwdata[UDC_RUN_BIT];
  end

  chk_run_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == UDC_CTRL |=> run_reg == $past(pwdata[UDC_RUN_BIT]))
    else $error("run bit not written");

  // Operand registers, one set per counter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < UDC_N; i++)
      begin
        upper_reg[i] <= UDC_ZERO;
        lower_reg[i] <= UDC_ZERO;
        start_reg[i] <= UDC_ZERO;
      end
    end
    else if (wr_en && is_cnt(paddr))
    begin
      unique case (cnt_sel(paddr))
        UDC_SEL_UP:  upper_reg[cnt_idx(paddr)] <= pwdata;
        UDC_SEL_LO:  lower_reg[cnt_idx(paddr)] <= pwdata;
        UDC_SEL_SV:  start_reg[cnt_idx(paddr)] <= pwdata;
        UDC_SEL_VAL: ;
      endcase
    end
  end

  generate
    for (genvar g = 0; g < UDC_N; g++)
    begin : g_cnt
      assign cif[g].count_rise  = count_rise[g];
      assign cif[g].dir_up      = dir_s2_reg[g];
      assign cif[g].clear       = clr_s2_reg[g];
      assign cif[g].preset_rise = preset_rise[g];
      assign cif[g].run         = run_reg;
      assign cif[g].upper       = upper_reg[g];
      assign cif[g].lower       = lower_reg[g];
      assign cif[g].start       = start_reg[g];

      udc_core u_core
      (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif[g])
      );

      assign actual_value_out[g] = cif[g].value;
      assign upper_limit_flag[g] = cif[g].up_flag;
      assign lower_limit_flag[g] = cif[g].lo_flag;
      assign zero_flag[g]        = cif[g].zero_flag;
      assign overflow_flag[g]    = cif[g].ovf_flag;
      assign ovf_evt[g]          = cif[g].ovf_flag;

      chk_count_up: assert property (@(posedge pclk) disable iff (!presetn)
        run_reg && count_rise[g] && dir_s2_reg[g] && !clr_s2_reg[g] && !preset_rise[g]
        && cif[g].value != UDC_VAL_MAX
        |=> cif[g].value == $past(cif[g].value) + UDC_STEP)
        else $error("up count missed");

      chk_count_down: assert property (@(posedge pclk) disable iff (!presetn)
        run_reg && count_rise[g] && !dir_s2_reg[g] && !clr_s2_reg[g] && !preset_rise[g]
        && cif[g].value != UDC_VAL_MIN
        |=> cif[g].value == $past(cif[g].value) - UDC_STEP)
        else $error("down count missed");

      chk_clear_wins: assert property (@(posedge pclk) disable iff (!presetn)
        clr_s2_reg[g] |=> cif[g].value == UDC_ZERO && zero_flag[g])
        else $error("clear did not zero the value");

      chk_preset_load: assert property (@(posedge pclk) disable iff (!presetn)
        preset_rise[g] && !clr_s2_reg[g] |=> cif[g].value == $past(start_reg[g]))
        else $error("preset not loaded");

      chk_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
        !run_reg && !clr_s2_reg[g] && !preset_rise[g]
        |=> cif[g].value == $past(cif[g].value))
        else $error("counter moved in stop mode");

      chk_upper_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(upper_reg[g])
        |-> upper_limit_flag[g] == ($signed(cif[g].value) >= $signed(upper_reg[g])))
        else $error("upper flag wrong");

      chk_lower_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(lower_reg[g])
        |-> lower_limit_flag[g] == ($signed(cif[g].value) <= $signed(lower_reg[g])))
        else $error("lower flag wrong");

      chk_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
        zero_flag[g] == (cif[g].value == UDC_ZERO))
        else $error("zero flag wrong");

      chk_ovf_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        run_reg && count_rise[g] && dir_s2_reg[g] && !clr_s2_reg[g] && !preset_rise[g]
        && cif[g].value == UDC_VAL_MAX
        |=> overflow_flag[g] ##1 !overflow_flag[g])
        else $error("overflow pulse wrong");

      chk_ovf_floor: assert property (@(posedge pclk) disable iff (!presetn)
        run_reg && count_rise[g] && !dir_s2_reg[g] && !clr_s2_reg[g] && !preset_rise[g]
        && cif[g].value == UDC_VAL_MIN
        |=> overflow_flag[g] && cif[g].value == UDC_VAL_MIN)
        else $error("underflow not held");
    end
  endgenerate

  // Overflow events are sticky; a new event wins over a clear in the same cycle.
  always_comb
  begin
    status_next = status_reg;
    if (wr_en && paddr == UDC_IRQ_CLR)
      status_next = status_reg & ~pwdata[15:0];
    status_next = status_next | ovf_evt;
  end

  always_comb
  begin
    irq_en_next = irq_en_reg;
    if (wr_en && paddr == UDC_IRQ_EN)
      irq_en_next = pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= UDC_RST16;
      irq_en_reg <= UDC_RST16;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_en_reg <= irq_en_next;
      irq_reg    <= |(status_next & irq_en_next);
    end
  end

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(status_reg & irq_en_reg))
    else $error("interrupt level wrong");

  chk_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    |ovf_evt |=> (status_reg & $past(ovf_evt)) == $past(ovf_evt))
    else $error("overflow event not kept in status");

  // Read data and the answer are prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= UDC_ZERO;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !is_cnt(paddr) && !is_global(paddr);
      prdata_reg  <= UDC_ZERO;
      if (setup && !pwrite)
      begin
        if (is_cnt(paddr))
        begin
          unique case (cnt_sel(paddr))
            UDC_SEL_UP:  prdata_reg <= upper_reg[cnt_idx(paddr)];
            UDC_SEL_LO:  prdata_reg <= lower_reg[cnt_idx(paddr)];
            UDC_SEL_SV:  prdata_reg <= start_reg[cnt_idx(paddr)];
            UDC_SEL_VAL: prdata_reg <= actual_value_out[cnt_idx(paddr)];
          endcase
        end
        else if (paddr == UDC_CTRL)
          prdata_reg <= {31'h0, run_reg};
        else if (paddr == UDC_STATUS)
          prdata_reg <= {16'h0, status_reg};
        else if (paddr == UDC_IRQ_EN)
          prdata_reg <= {16'h0, irq_en_reg};
      end
    end
  end

  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access cycle");

  chk_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !is_cnt(paddr) && !is_global(paddr) |=> pready && pslverr)
    else $error("unmapped access not refused");

  chk_apb_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> !pready)
    else $error("pready without a setup cycle");

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;
endmodule : udc_bank

// file: common/udc_pkg.sv
// Constants shared by the up/down pulse counter bank and its cores.
// Assumes a 32-bit APB with byte addresses and one aligned word per register.
package udc_pkg;
  localparam int          UDC_N        = 16;
  localparam int          UDC_W        = 32;
  localparam int          UDC_AW       = 12;
  localparam logic [31:0] UDC_VAL_MAX  = 32'h7fffffff;
  localparam logic [31:0] UDC_VAL_MIN  = 32'h80000000;
  localparam logic [31:0] UDC_ZERO     = 32'h00000000;
  localparam logic [31:0] UDC_STEP     = 32'h00000001;
  localparam logic [11:0] UDC_CTRL     = 12'h000;
  localparam logic [11:0] UDC_STATUS   = 12'h004;
  localparam logic [11:0] UDC_IRQ_EN   = 12'h008;
  localparam logic [11:0] UDC_IRQ_CLR  = 12'h00c;
  localparam logic [3:0]  UDC_CNT_PAGE = 4'h1;
  localparam logic [1:0]  UDC_SEL_UP   = 2'h0;
  localparam logic [1:0]  UDC_SEL_LO   = 2'h1;
  localparam logic [1:0]  UDC_SEL_SV   = 2'h2;
  localparam logic [1:0]  UDC_SEL_VAL  = 2'h3;
  localparam int          UDC_RUN_BIT  = 0;
  localparam logic [15:0] UDC_RST16    = 16'h0000;
endpackage : udc_pkg

// file: common/udc_core_if.sv
// Signals between the bank controller and one counter core.
// Assumes both ends run on the same pclk.
interface udc_core_if;
  logic        count_rise;
  logic        dir_up;
  logic        clear;
  logic        preset_rise;
  logic        run;
  logic [31:0] upper;
  logic [31:0] lower;
  logic [31:0] start;
  logic [31:0] value;
  logic        up_flag;
  logic        lo_flag;
  logic        zero_flag;
  logic        ovf_flag;
  modport ctl  (output count_rise, dir_up, clear, preset_rise, run, upper, lower, start,
                input value, up_flag, lo_flag, zero_flag, ovf_flag);
  modport core (input count_rise, dir_up, clear, preset_rise, run, upper, lower, start,
                output value, up_flag, lo_flag, zero_flag, ovf_flag);
endinterface : udc_core_if

// file: rtl/udc_core.sv
// One signed 32-bit up/down counter with limit, zero and overflow flags.
// Assumes coil events arrive already synchronised and edge detected.
module udc_core
  import udc_pkg::*;
(
  input wire logic  pclk,
  input wire logic  presetn,
  udc_core_if.core  cif
);
  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic        ovf_next;
  logic        up_reg;
  logic        lo_reg;
  logic        zero_reg;
  logic        ovf_reg;

  always_comb
  begin
    value_next = value_reg;
    ovf_next   = 1'b0;
    if (cif.clear)
      value_next = UDC_ZERO;
    else if (cif.preset_rise)
      value_next = cif.start;
    else if (cif.run && cif.count_rise)
    begin
      if (cif.dir_up)
      begin
        if (value_reg == UDC_VAL_MAX)
          ovf_next = 1'b1;
        else
          value_next = value_reg + UDC_STEP;
      end
      else
      begin
        if (value_reg == UDC_VAL_MIN)
          ovf_next = 1'b1;
        else
          value_next = value_reg - UDC_STEP;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      value_reg <= UDC_ZERO;
    else
      value_reg <= value_next;
  end

  // Flags track the new value in the same cycle it appears.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_reg   <= 1'b1;
      lo_reg   <= 1'b1;
      zero_reg <= 1'b1;
      ovf_reg  <= 1'b0;
    end
    else
    begin
      up_reg   <= $signed(value_next) >= $signed(cif.upper);
      lo_reg   <= $signed(value_next) <= $signed(cif.lower);
      zero_reg <= value_next == UDC_ZERO;
      ovf_reg  <= ovf_next;
    end
  end

  assign cif.value     = value_reg;
  assign cif.up_flag   = up_reg;
  assign cif.lo_flag   = lo_reg;
  assign cif.zero_flag = zero_reg;
  assign cif.ovf_flag  = ovf_reg;

  chk_ovf_hold_value: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_reg |-> value_reg == $past(value_reg))
    else $error("value changed on overflow");
endmodule : udc_core

// file: verif/udc_coil_drv.sv
// Model of the user circuit logic that drives the counter coils.
// Assumes all coil changes are made just after a rising edge of pclk.
module udc_coil_drv
  import udc_pkg::*;
(
  input  wire logic             pclk,
  output logic      [UDC_N-1:0] count_coil,
  output logic      [UDC_N-1:0] direction_coil,
  output logic      [UDC_N-1:0] clear_coil,
  output logic      [UDC_N-1:0] preset_load_coil
);
  initial
  begin
    count_coil       = '0;
    direction_coil   = '0;
    clear_coil       = '0;
    preset_load_coil = '0;
  end

  // Square count pulses, three cycles high and three low, so none is lost.
  task automatic pulse(input int i, input logic up, input int n);
    @(posedge pclk);
    direction_coil[i] <= up;
    repeat (n)
    begin
      @(posedge pclk);
      count_coil[i] <= 1'b1;
      repeat (3) @(posedge pclk);
      count_coil[i] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : pulse

  // Raises the chosen coils on one edge and releases them three cycles later.
  task automatic hit(input int i, input logic c, input logic p, input logic k);
    @(posedge pclk);
    clear_coil[i]       <= c;
    preset_load_coil[i] <= p;
    count_coil[i]       <= k;
    repeat (3) @(posedge pclk);
    clear_coil[i]       <= 1'b0;
    preset_load_coil[i] <= 1'b0;
    count_coil[i]       <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : hit
endmodule : udc_coil_drv

// file: verif/tb_top.sv
// Self-checking bench for the counter bank: APB master tasks and coil scenarios.
// Assumes the coil driver model and the bank share one 25 MHz clock.
module tb_top
  import udc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [UDC_AW-1:0]           paddr;
  logic [31:0]                 pwdata, prdata, q;
  logic                        e;
  logic [UDC_N-1:0]            cc, dc, kc, pc, ufl, lfl, zfl, ofl;
  logic [UDC_N-1:0][UDC_W-1:0] val;
  int                          err_total, checks_done, ovf_seen;

  udc_bank udc_bank_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_coil(cc), .direction_coil(dc), .clear_coil(kc),
    .preset_load_coil(pc), .actual_value_out(val), .upper_limit_flag(ufl),
    .lower_limit_flag(lfl), .zero_flag(zfl), .overflow_flag(ofl), .irq(irq));
  udc_coil_drv udc_coil_drv_i (.pclk(pclk), .count_coil(cc), .direction_coil(dc),
    .clear_coil(kc), .preset_load_coil(pc));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (ofl[0] === 1'b1) ovf_seen++;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
  endtask : apb

  function automatic logic [11:0] ca(input logic [3:0] n, input logic [1:0] s);
    return {UDC_CNT_PAGE, n, s, 2'h0};
  endfunction : ca

  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask : settle

  task automatic chk0(input logic [31:0] v, input logic [2:0] f, input string m);
    settle();
    chk(val[0], v, m);
    chk({29'h0, ufl[0], lfl[0], zfl[0]}, {29'h0, f}, m);
  endtask : chk0

  initial
  begin
    #(40 * 5000);
    err_total++;
    test_done();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, err_total, checks_done, ovf_seen} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk0(32'h0, 3'h7, "reset flags");
    udc_coil_drv_i.pulse(0, 1'b1, 3);
    chk0(32'h0, 3'h7, "stop mode");
    apb(1'b1, UDC_CTRL, 32'h1);
    udc_coil_drv_i.pulse(0, 1'b1, 5);
    chk0(32'h5, 3'h4, "count up");
    chk(val[1], 32'h0, "neighbour");
    udc_coil_drv_i.pulse(0, 1'b0, 2);
    chk0(32'h3, 3'h4, "count down");
    apb(1'b0, ca(4'h0, UDC_SEL_VAL), 32'h0);
    chk(q, 32'h3, "value reg");
    $display("test counting done");
    apb(1'b1, ca(4'h0, UDC_SEL_UP), 32'h3);
    apb(1'b1, ca(4'h0, UDC_SEL_LO), 32'h3);
    chk0(32'h3, 3'h6, "at both limits");
    apb(1'b1, ca(4'h0, UDC_SEL_UP), 32'h4);
    apb(1'b1, ca(4'h0, UDC_SEL_LO), 32'hffffffff);
    chk0(32'h3, 3'h0, "between limits");
    $display("test limits done");
    apb(1'b1, ca(4'h0, UDC_SEL_SV), 32'h7ffffffe);
    udc_coil_drv_i.hit(0, 1'b0, 1'b1, 1'b0);
    chk0(32'h7ffffffe, 3'h4, "preset");
    udc_coil_drv_i.pulse(0, 1'b1, 1);
    chk0(UDC_VAL_MAX, 3'h4, "to max");
    chk(ovf_seen, 32'h0, "no overflow yet");
    udc_coil_drv_i.pulse(0, 1'b1, 1);
    chk0(UDC_VAL_MAX, 3'h4, "hold at max");
    chk(ovf_seen, 32'h1, "one overflow pulse");
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, UDC_STATUS, 32'h0);
    apb(1'b0, UDC_STATUS, 32'h0);
    chk(q, 32'h1, "sticky status");
    apb(1'b1, UDC_IRQ_EN, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, UDC_IRQ_CLR, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0, "irq cleared");
    apb(1'b0, UDC_STATUS, 32'h0);
    chk(q, 32'h0, "status cleared");
    $display("test overflow up done");
    apb(1'b1, ca(4'h0, UDC_SEL_SV), UDC_VAL_MIN);
    udc_coil_drv_i.hit(0, 1'b0, 1'b1, 1'b0);
    udc_coil_drv_i.pulse(0, 1'b0, 1);
    chk0(UDC_VAL_MIN, 3'h2, "hold at min");
    chk(ovf_seen, 32'h2, "second overflow");
    udc_coil_drv_i.hit(0, 1'b1, 1'b1, 1'b1);
    chk0(32'h0, 3'h1, "clear wins");
    udc_coil_drv_i.hit(0, 1'b0, 1'b1, 1'b1);
    chk0(UDC_VAL_MIN, 3'h2, "preset beats count");
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    $display("test priority done");
    test_done();
  end
endmodule : tb_top
